//--- rtl/cfg_if.sv
// Interface carrying mode fields from the register bank to the sequencer
`timescale 1ns/1ps
interface cfg_if;
  logic disc_en;           // Discontinuous mode
  logic continuous_mode_en;           // Continuous mode
  logic wait_en;           // Wait-for-conversion mode
  logic start_set;         // Software start pulse
  logic stop_set;          // Software stop pulse
  logic data_read;         // Software read of result, frees wait
  logic busy;              // Conversion-start flag
  logic stopping;          // Stop in progress
  logic conv_done;         // One conversion finished pulse
  logic seq_end;           // Sequence end pulse

  modport bank (output disc_en, continuous_mode_en, wait_en, start_set, stop_set,
    data_read, input busy, stopping, conv_done, seq_end);
  modport seq (input disc_en, continuous_mode_en, wait_en, start_set, stop_set,
    data_read, output busy, stopping, conv_done, seq_end);
endinterface

//--- rtl/cfg_pkg.sv
// Package holding the register map, field layout and mode codes
package cfg_pkg;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] CFG_ONE_OFFSET = 8'h0C;   // Config register
  localparam logic [7:0] CONV_CTRL_OFFSET = 8'h08; // Start/stop control
  localparam logic [31:0] CFG_ONE_RESET = 32'h00000000;
  localparam logic [31:0] CONV_CTRL_RESET = 32'h00000000;

  // ------------------------------------------------------------
  // Field positions in the config register
  // ------------------------------------------------------------
  localparam int WD_CH_LSB = 26;       // Watchdog channel field low bit
  localparam int WD_CH_MSB = 29;       // Watchdog channel field high bit
  localparam int WD_EN_BIT = 23;       // Watchdog enable
  localparam int WD_SGL_BIT = 22;      // Watchdog single-channel scope
  localparam int DISC_BIT = 16;        // Discontinuous enable
  localparam int WAIT_BIT = 14;        // Wait-for-conversion mode
  localparam int CONTINUOUS_MODE_BIT = 13;        // Continuous mode
  localparam int LOW_HALF_MSB = 12;    // Lower fields kept as storage
  localparam logic [31:0] CFG_LOW_MASK = 32'h00001DFC; // Lower writable

  // ------------------------------------------------------------
  // Field positions in the control register
  // ------------------------------------------------------------
  localparam int START_BIT = 2;        // Conversion start flag
  localparam int STOP_BIT = 4;         // Stop command

  // ------------------------------------------------------------
  // Channel code limits
  // ------------------------------------------------------------
  localparam logic [3:0] WD_CH_MAX_CODE = 4'h9;  // Last legal code
  localparam int NUM_INPUTS = 11;                // Inputs 0 to 10

  // ------------------------------------------------------------
  // Sequencer timing
  // ------------------------------------------------------------
  localparam int CONV_NS = 1000;                  // One conversion time
  localparam int CLK_NS = 25;                     // Clock period
  localparam int CONV_CYCLES = (CONV_NS + CLK_NS - 1) / CLK_NS;

  // Sequencer states
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_CONV = 3'b010,
    SEQ_TRIG = 3'b100
  } seq_state_t;

endpackage

//--- rtl/conv_sequencer.sv
// Conversion sequencer model that owns the conversion-start flag
`timescale 1ns/1ps
module conv_sequencer
  import cfg_pkg::*;
#(
  parameter int CYCLES = CONV_CYCLES,
  parameter int SEQ_LEN = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Mode and status link
  cfg_if.seq link
);
  import cfg_pkg::*;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  seq_state_t state_reg;        // Sequencer state
  logic [15:0] cnt_reg;         // Cycle count within a conversion
  logic [7:0] idx_reg;          // Conversion index within sequence
  logic stop_reg;               // Stop command pending

  // Outputs from state
  assign link.busy = (state_reg != SEQ_IDLE);
  assign link.stopping = stop_reg;
  assign link.conv_done = (state_reg == SEQ_CONV) &&
    (cnt_reg == 16'(CYCLES - 1));
  assign link.seq_end = link.conv_done && (idx_reg == 8'(SEQ_LEN - 1));

  // Sequencer state machine; flag clears at end or stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= SEQ_IDLE;
      cnt_reg <= 16'h0000;
      idx_reg <= 8'h00;
    end else if (stop_reg) begin
      state_reg <= SEQ_IDLE; // R12
      cnt_reg <= 16'h0000;
      idx_reg <= 8'h00;
    end else begin
      case (state_reg)
        SEQ_IDLE: begin
          // Start by software
          if (link.start_set) begin
            state_reg <= SEQ_CONV; // R12
            cnt_reg <= 16'h0000;
          end
        end
        SEQ_CONV: begin
          if (!link.conv_done) begin
            cnt_reg <= cnt_reg + 16'h0001;
          end else if (link.wait_en) begin
            // Hold until result is read
            state_reg <= SEQ_TRIG; // R10
          end else if (link.disc_en) begin
            // One conversion per start
            state_reg <= SEQ_IDLE; // R7
            idx_reg <= link.seq_end ? 8'h00 : idx_reg + 8'h01;
          end else if (link.seq_end && !link.continuous_mode_en) begin
            // Single mode ends with the sequence
            state_reg <= SEQ_IDLE; // R11
            idx_reg <= 8'h00;
          end else begin
            // Next conversion, wrapping in continuous mode
            cnt_reg <= 16'h0000; // R11
            idx_reg <= link.seq_end ? 8'h00 : idx_reg + 8'h01;
          end
        end
        SEQ_TRIG: begin
          // Wait state freed by a read; finish the step it held
          if (link.data_read) begin
            if (link.disc_en ||
                (idx_reg == 8'(SEQ_LEN - 1) && !link.continuous_mode_en)) begin
              state_reg <= SEQ_IDLE; // R7 R11
            end else begin
              state_reg <= SEQ_CONV; // R10
            end
            cnt_reg <= 16'h0000;
            idx_reg <= (idx_reg == 8'(SEQ_LEN - 1)) ? 8'h00 :
              idx_reg + 8'h01;
          end
        end
        default: state_reg <= SEQ_IDLE;
      endcase
    end
  end

  // Stop command lasts one cycle while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_reg <= 1'b0;
    end else begin
      stop_reg <= link.stop_set && link.busy && !stop_reg;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  stop_clears_flag_a: assert property ( // R12
    @(posedge pclk) disable iff (!presetn)
    stop_reg |=> !link.busy)
    else $error("Start flag not cleared after stop");

  start_sets_flag_a: assert property ( // R12
    @(posedge pclk) disable iff (!presetn)
    (!link.busy && link.start_set && !stop_reg) |=> link.busy)
    else $error("Start flag not set by start");

  single_ends_a: assert property ( // R11
    @(posedge pclk) disable iff (!presetn)
    (link.seq_end && !link.continuous_mode_en && !link.wait_en && !stop_reg)
      |=> !link.busy)
    else $error("Single mode did not end with sequence");

  continuous_mode_runs_a: assert property ( // R11
    @(posedge pclk) disable iff (!presetn)
    (link.seq_end && link.continuous_mode_en && !link.wait_en &&
      !link.disc_en && !stop_reg) |=> link.busy)
    else $error("Continuous mode stopped on its own");

  disc_ends_a: assert property ( // R7
    @(posedge pclk) disable iff (!presetn)
    (link.conv_done && link.disc_en && !link.wait_en && !stop_reg)
      |=> !link.busy)
    else $error("Discontinuous mode ran past one conversion");

  cover_continuous_mode_c: cover property (
    @(posedge pclk) disable iff (!presetn)
    link.seq_end && link.continuous_mode_en);
  cover_stop_c: cover property (
    @(posedge pclk) disable iff (!presetn) stop_reg);
  cover_wait_c: cover property (
    @(posedge pclk) disable iff (!presetn)
    state_reg == SEQ_TRIG ##1 link.data_read);
endmodule

//--- rtl/converter_config_one.sv
// APB register bank for the first converter configuration register
`timescale 1ns/1ps
// Operation
// R1 - Config register at 0x0C, resets zero
// R2 - Bits 29:26 pick inputs one to ten
// R3 - Input zero has no single watchdog
// R4 - Software also enables that channel's conversion
// R5 - Bit 23 switches watchdog on
// R6 - Bit 22 limits watchdog to one channel
// R7 - Bit 16 enables discontinuous mode
// R8 - Software never sets discontinuous with continuous
// R9 - Mode fields written only while idle
// R10 - Bit 14 enables wait-for-conversion mode
// R11 - Bit 13 repeats conversions until cleared
// R12 - Start flag set by software, hardware clears
// R13 - Reserved bits read zero, ignore writes
// R14 - Defined fields read back last write
module converter_config_one
  import cfg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Result read strobe from the data path
  input wire logic result_read,
  // Mode outputs to the converter
  output logic [3:0] watchdog_channel_sel,
  output logic watchdog_enable,
  output logic watchdog_single_channel,
  output logic discontinuous_enable,
  output logic wait_mode,
  output logic continuous_mode,
  output logic [10:0] watchdog_monitor,
  output logic conversion_start_flag
);
  import cfg_pkg::*;

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [31:0] cfg_reg;          // Config register contents
  logic [31:0] cfg_next;         // Next config value
  logic [31:0] rdata_next;       // Read mux
  logic wr_en;                   // Write access phase
  logic rd_en;                   // Read access phase
  logic hit_cfg;                 // Address hits config register
  logic hit_ctrl;                // Address hits control register
  logic [31:0] wmask;            // Byte lane mask
  logic [31:0] cfg_write_mask;   // Bits writable now
  logic [31:0] ctrl_view;        // Control register read view

  cfg_if link ();

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;

  // Address decode
  always_comb begin
    hit_cfg = 1'b0;
    hit_ctrl = 1'b0;
    if (paddr == CFG_ONE_OFFSET) begin
      hit_cfg = 1'b1; // R1
    end else if (paddr == CONV_CTRL_OFFSET) begin
      hit_ctrl = 1'b1;
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_cfg && !hit_ctrl;

  // Byte enable expansion
  assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
    {8{pstrb[0]}}};

  // Defined fields only; every field locked while converting
  always_comb begin
    cfg_write_mask = CFG_LOW_MASK; // R13
    if (!link.busy) begin
      cfg_write_mask[WD_CH_MSB:WD_CH_LSB] = 4'hF; // R9
      cfg_write_mask[WD_EN_BIT] = 1'b1;
      cfg_write_mask[WD_SGL_BIT] = 1'b1;
      cfg_write_mask[DISC_BIT] = 1'b1;
      cfg_write_mask[WAIT_BIT] = 1'b1;
      cfg_write_mask[CONTINUOUS_MODE_BIT] = 1'b1;
    end else begin
      cfg_write_mask = 32'h00000000; // R9
    end
  end

  // Next config value from a masked write
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_en && hit_cfg) begin
      cfg_next = (cfg_reg & ~(wmask & cfg_write_mask)) |
        (pwdata & wmask & cfg_write_mask); // R14
    end
  end

  // ------------------------------------------------------------
  // Config register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= CFG_ONE_RESET; // R1
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Field outputs
  assign watchdog_channel_sel = cfg_reg[WD_CH_MSB:WD_CH_LSB]; // R2
  assign watchdog_enable = cfg_reg[WD_EN_BIT]; // R5
  assign watchdog_single_channel = cfg_reg[WD_SGL_BIT]; // R6
  assign discontinuous_enable = cfg_reg[DISC_BIT]; // R7
  assign wait_mode = cfg_reg[WAIT_BIT]; // R10
  assign continuous_mode = cfg_reg[CONTINUOUS_MODE_BIT]; // R11
  assign conversion_start_flag = link.busy; // R12

  // ------------------------------------------------------------
  // Sequencer link
  // ------------------------------------------------------------
  assign link.disc_en = cfg_reg[DISC_BIT];
  assign link.continuous_mode_en = cfg_reg[CONTINUOUS_MODE_BIT];
  assign link.wait_en = cfg_reg[WAIT_BIT];
  assign link.data_read = result_read;
  assign link.start_set = wr_en && hit_ctrl && pstrb[0] &&
    pwdata[START_BIT]; // R12
  assign link.stop_set = wr_en && hit_ctrl && pstrb[0] &&
    pwdata[STOP_BIT];

  conv_sequencer u_seq (
    .pclk(pclk),
    .presetn(presetn),
    .link(link)
  );

  wd_channel_map u_map (
    .enable(cfg_reg[WD_EN_BIT]),
    .single(cfg_reg[WD_SGL_BIT]),
    .code(cfg_reg[WD_CH_MSB:WD_CH_LSB]),
    .monitor(watchdog_monitor)
  );

  // ------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------
  always_comb begin
    ctrl_view = CONV_CTRL_RESET;
    ctrl_view[START_BIT] = link.busy;
    ctrl_view[STOP_BIT] = link.stopping;
  end

  // Read mux
  always_comb begin
    rdata_next = 32'h00000000;
    if (hit_cfg) begin
      rdata_next = cfg_reg; // R13 R14
    end else if (hit_ctrl) begin
      rdata_next = ctrl_view;
    end
  end

  // Read data held in a flop, loaded at setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdata_next;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  reserved_zero_a: assert property ( // R13
    @(posedge pclk) disable iff (!presetn)
    (cfg_reg & 32'hC33E8203) == 32'h00000000)
    else $error("Reserved config bit set");

  write_back_a: assert property ( // R14
    @(posedge pclk) disable iff (!presetn)
    (wr_en && hit_cfg && !link.busy && pstrb == 4'hF) |=>
      cfg_reg[29:13] == ($past(pwdata[29:13]) & 17'h1E60B))
    else $error("Config field did not take written value");

  busy_lock_a: assert property ( // R9
    @(posedge pclk) disable iff (!presetn)
    link.busy |=> cfg_reg[29:13] == $past(cfg_reg[29:13]))
    else $error("Mode field changed while converting");

  reset_value_a: assert property ( // R1
    @(posedge pclk) $rose(presetn) |-> cfg_reg == 32'h00000000)
    else $error("Config register not zero after reset");

  enable_out_a: assert property ( // R5
    @(posedge pclk) disable iff (!presetn)
    !watchdog_enable |-> watchdog_monitor == 11'h000)
    else $error("Watchdog monitoring while disabled");

  scope_all_a: assert property ( // R6
    @(posedge pclk) disable iff (!presetn)
    (watchdog_enable && !watchdog_single_channel) |->
      watchdog_monitor == 11'h7FF)
    else $error("All-channel scope not applied");

  single_map_a: assert property ( // R2
    @(posedge pclk) disable iff (!presetn)
    (watchdog_enable && watchdog_single_channel &&
      watchdog_channel_sel == 4'h9) |-> watchdog_monitor == 11'h400)
    else $error("Code nine did not select input ten");

  wait_hold_a: assert property ( // R10
    @(posedge pclk) disable iff (!presetn)
    (link.conv_done && wait_mode && !link.stopping) |=>
      link.busy ##1 (link.busy || $past(result_read) || link.stopping))
    else $error("Wait mode did not hold for read");

  unmapped_err_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && paddr == 8'h00) |-> pslverr)
    else $error("Unmapped address gave no error");

  cover_write_c: cover property (
    @(posedge pclk) disable iff (!presetn) wr_en && hit_cfg);
  cover_single_c: cover property (
    @(posedge pclk) disable iff (!presetn)
    watchdog_enable && watchdog_single_channel);
endmodule

//--- rtl/wd_channel_map.sv
// Decodes the watchdog fields into an input monitor map, one-hot when enabled in single-channel scope with codes 0 to 9
`timescale 1ns/1ps
module wd_channel_map
  import cfg_pkg::*;
#(
  parameter int INPUTS = NUM_INPUTS
) (
  // Watchdog fields
  input wire logic enable,
  input wire logic single,
  input wire logic [3:0] code,
  // Monitored inputs, bit n for input n
  output logic [INPUTS-1:0] monitor
);
  import cfg_pkg::*;

  // Code 0 is input 1; input 0 is never chosen alone
  always_comb begin
    monitor = '0;
    if (enable) begin
      if (!single) begin
        monitor = '1; // R6
      end else if (code <= WD_CH_MAX_CODE) begin
        monitor[int'(code) + 1] = 1'b1; // R2 R3
      end
    end
  end

  input_zero_a: assert property ( // R3
    @(negedge enable) single |-> !monitor[0])
    else $error("Input zero chosen in single mode");
endmodule

//--- verif/converter_config_one_tb.sv
// Self-checking bench for the converter config register bank
`timescale 1ns/1ps
module converter_config_one_tb;
  import cfg_pkg::*;
  // ------------------------------------------------------------
  // Constants and signals
  // ------------------------------------------------------------
  localparam int SEQ_N = 4;                        // Sequence length
  localparam logic [31:0] UP_MASK = 32'h3CC16000;  // Upper defined bits
  localparam logic [31:0] RW_MASK = UP_MASK | CFG_LOW_MASK;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic result_read;
  logic [3:0] watchdog_channel_sel;
  logic watchdog_enable;
  logic watchdog_single_channel;
  logic discontinuous_enable;
  logic wait_mode;
  logic continuous_mode;
  logic [10:0] watchdog_monitor;
  logic conversion_start_flag;
  int n_fail;        // Mismatch count
  int comparisons;   // Comparison count

  // Device under test
  converter_config_one u_converter_config_one (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .result_read(result_read),
    .watchdog_channel_sel(watchdog_channel_sel),
    .watchdog_enable(watchdog_enable),
    .watchdog_single_channel(watchdog_single_channel),
    .discontinuous_enable(discontinuous_enable), .wait_mode(wait_mode),
    .continuous_mode(continuous_mode), .watchdog_monitor(watchdog_monitor),
    .conversion_start_flag(conversion_start_flag));

  // Clock at 40 MHz
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  // Verdict and end of run
  task automatic end_of_test();
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Value comparison
  task automatic check(string name, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", name, e, g);
      n_fail++;
    end
  endtask

  // Count comparison against a window
  task automatic check_range(string name, int lo, int hi, int g);
    comparisons++;
    if (g < lo || g > hi) begin
      $display("wrong value %s expected %0d to %0d seen %0d",
               name, lo, hi, g);
      n_fail++;
    end
  endtask

  // One APB transfer, then one idle edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    // A slave that never answers counts as a mismatch
    if (pready !== 1'b1) begin
      n_fail++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Full-word write
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, 4'hF, r, e);
  endtask

  // Read and compare
  task automatic rd_check(string name, logic [7:0] a, logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h00000000, 4'hF, r, e);
    check(name, x, r);
  endtask

  // Mode outputs against an expected register word
  task automatic check_fields(logic [31:0] x);
    check("channel", 32'(x[WD_CH_MSB:WD_CH_LSB]),
          32'(watchdog_channel_sel));
    check("wd enable", 32'(x[WD_EN_BIT]), 32'(watchdog_enable));
    check("wd single", 32'(x[WD_SGL_BIT]),
          32'(watchdog_single_channel));
    check("disc", 32'(x[DISC_BIT]), 32'(discontinuous_enable));
    check("wait", 32'(x[WAIT_BIT]), 32'(wait_mode));
    check("continuous_mode", 32'(x[CONTINUOUS_MODE_BIT]), 32'(continuous_mode));
  endtask

  // Wait a bounded time for the start flag level, sampled mid-cycle
  task automatic wait_flag(logic v, int max);
    int n;
    n = 0;
    @(negedge pclk);
    while (conversion_start_flag !== v && n < max) begin
      @(negedge pclk);
      n++;
    end
    check("start flag", 32'(v), 32'(conversion_start_flag));
    @(posedge pclk);
  endtask

  // Cycles the start flag stays high, capped, sampled mid-cycle
  task automatic span(int max, output int n);
    n = 0;
    @(negedge pclk);
    while (conversion_start_flag === 1'b1 && n < max) begin
      @(negedge pclk);
      n++;
    end
    @(posedge pclk);
  endtask

  // Configure, start, and measure a sequence
  task automatic run_seq(logic [31:0] cfg, int max, output int n);
    wr(CFG_ONE_OFFSET, cfg);
    wr(CONV_CTRL_OFFSET, 32'h1 << START_BIT);
    wait_flag(1'b1, 4);
    span(max, n);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Reset value and idle outputs
  task automatic test_reset();
    rd_check("cfg reset", CFG_ONE_OFFSET, CFG_ONE_RESET);
    check_fields(CFG_ONE_RESET);
    check("flag idle", 32'h0, 32'(conversion_start_flag));
  endtask

  // Readback of defined bits, reserved bits dropped
  task automatic test_fields();
    wr(CFG_ONE_OFFSET, 32'hFFFFDFFF);
    rd_check("cfg all", CFG_ONE_OFFSET, 32'hFFFFDFFF & RW_MASK);
    check_fields(32'hFFFFDFFF);
    wr(CFG_ONE_OFFSET, 32'h1 << CONTINUOUS_MODE_BIT);
    rd_check("cfg continuous_mode", CFG_ONE_OFFSET, 32'h1 << CONTINUOUS_MODE_BIT);
    check_fields(32'h1 << CONTINUOUS_MODE_BIT);
  endtask

  // Byte strobes on the upper lanes
  task automatic test_strobe();
    logic [31:0] r;
    logic e;
    wr(CFG_ONE_OFFSET, 32'h00000000);
    apb(1'b1, CFG_ONE_OFFSET, 32'hFFFFFFFF, 4'h8, r, e);
    rd_check("lane 3", CFG_ONE_OFFSET, 32'h3C000000);
    apb(1'b1, CFG_ONE_OFFSET, 32'hFFFFFFFF, 4'h4, r, e);
    rd_check("lane 2", CFG_ONE_OFFSET, 32'h3CC10000);
  endtask

  // Every channel code, both scopes, enable off
  task automatic test_channels();
    logic [10:0] x;
    for (int c = 0; c < 16; c++) begin
      wr(CFG_ONE_OFFSET, (32'(c) << WD_CH_LSB) | 32'h00C00000);
      x = (c <= 9) ? 11'h001 << (c + 1) : 11'h000;
      check("monitor one", 32'(x), 32'(watchdog_monitor));
    end
    wr(CFG_ONE_OFFSET, 32'h1 << WD_EN_BIT);
    check("monitor all", 32'h7FF, 32'(watchdog_monitor));
    wr(CFG_ONE_OFFSET, 32'h1 << WD_SGL_BIT);
    check("monitor off", 32'h0, 32'(watchdog_monitor));
  endtask

  // Single and discontinuous sequence lengths
  task automatic test_single_disc();
    int n;
    run_seq(32'h00000000, 2000, n);
    check_range("single len", SEQ_N * CONV_CYCLES - 4,
                SEQ_N * CONV_CYCLES + 8, n);
    run_seq(32'h1 << DISC_BIT, 2000, n);
    check_range("disc len", CONV_CYCLES - 4, CONV_CYCLES + 8, n);
  endtask

  // Continuous run, refused write, stop
  task automatic test_continuous_mode();
    int n;
    run_seq(32'h1 << CONTINUOUS_MODE_BIT, 300, n);
    check_range("continuous_mode len", 300, 300, n);
    rd_check("ctrl busy", CONV_CTRL_OFFSET, 32'h1 << START_BIT);
    wr(CFG_ONE_OFFSET, 32'h00800000);
    rd_check("cfg busy", CFG_ONE_OFFSET, 32'h1 << CONTINUOUS_MODE_BIT);
    wr(CONV_CTRL_OFFSET, 32'h1 << STOP_BIT);
    wait_flag(1'b0, 8);
  endtask

  // Wait mode holds the flag until the result is read
  task automatic test_wait();
    int n;
    run_seq((32'h1 << WAIT_BIT) | (32'h1 << DISC_BIT), 200, n);
    check_range("wait hold", 200, 200, n);
    result_read <= 1'b1;
    @(posedge pclk);
    result_read <= 1'b0;
    wait_flag(1'b0, 8);
  endtask

  // Unmapped address flags an error and changes nothing
  task automatic test_unmapped();
    logic [31:0] r;
    logic e;
    wr(CFG_ONE_OFFSET, 32'h24400000);
    apb(1'b1, 8'h00, 32'hFFFFFFFF, 4'hF, r, e);
    check("err write", 32'h1, 32'(e));
    apb(1'b0, 8'h00, 32'h00000000, 4'hF, r, e);
    check("err read", 32'h1, 32'(e));
    check("data unmapped", 32'h0, r);
    rd_check("cfg kept", CFG_ONE_OFFSET, 32'h24400000);
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    n_fail = 0;
    comparisons = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    result_read = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    test_reset();
    test_fields();
    test_strobe();
    test_channels();
    test_single_disc();
    test_continuous_mode();
    test_wait();
    test_unmapped();
    end_of_test();
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_of_test();
  end
endmodule
